// [hw/sdf_pkg.sv]
// constants and types shared by the decimation filter files
package sdf_pkg;
	// channel count and data widths
	localparam int CHANNELS   = 8;
	localparam int RESULT_W   = 24;
	localparam int CIC_W      = 24;
	localparam int COMB_W     = 23;
	localparam int ACC_W      = 32;

	// oversampling ratios (modulator samples per output word)
	localparam int OSR_STD    = 64;
	localparam int OSR_HIRES  = 128;
	localparam int DEC_W      = 7;
	localparam logic [DEC_W-1:0] DEC_LAST_STD   = DEC_W'(OSR_STD - 1);
	localparam logic [DEC_W-1:0] DEC_LAST_HIRES = DEC_W'(OSR_HIRES - 1);

	// master clock divide ratios for the modulator sample rate
	localparam int DIV_W = 6;
	localparam logic [DIV_W-1:0] DIV_FAST = 6'h04;
	localparam logic [DIV_W-1:0] DIV_MID  = 6'h08;
	localparam logic [DIV_W-1:0] DIV_SLOW = 6'h28;

	// second stage: delay line with a symmetric 1-2-1 kernel at its far end
	localparam int HIST_DEPTH    = 34;
	localparam int FIR_TAP_FIRST = 31;

	// left shift that brings each path's gain to 2^23 at full scale
	localparam logic [1:0] SCALE_SHIFT_STD   = 2'h3;
	localparam logic [1:0] SCALE_SHIFT_HIRES = 2'h0;

	// output clip codes and reset value
	localparam logic signed [ACC_W-1:0] RESULT_MAX = 32'sh007FFFFF;
	localparam logic signed [ACC_W-1:0] RESULT_MIN = 32'shFF800000;
	localparam logic [RESULT_W-1:0]     RESULT_RST = 24'h000000;

	typedef enum logic [1:0] {
		MODE_HIGH_SPEED      = 2'b00,
		MODE_HIGH_RESOLUTION = 2'b01,
		MODE_LOW_POWER       = 2'b10,
		MODE_LOW_SPEED       = 2'b11
	} op_mode_e;

	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'b00,
		SEQ_CALC    = 2'b01,
		SEQ_PUBLISH = 2'b10
	} seq_state_e;
endpackage

// [hw/filter_ctl_if.sv]
// shared timing strobes from the rate divider and decimation phase counter to every channel filter
`timescale 1ns/10ps
interface filter_ctl_if;
	logic tick;
	logic dump;
	logic clear;

	modport ctl  (output tick, output dump, output clear);
	modport chan (input tick, input dump, input clear);
endinterface

// [hw/decim_channel.sv]
// one channel's third-order boxcar decimator (first filter stage)
`timescale 1ns/10ps
module decim_channel
	import sdf_pkg::*;
(
	filter_ctl_if.chan                 ctl,
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_nrst,
	input  wire logic                  i_density_bit,
	output logic signed [COMB_W-1:0]   o_comb
);
	logic signed [CIC_W-1:0]  int1_reg, int1_next;
	logic signed [CIC_W-1:0]  int2_reg, int2_next;
	logic signed [CIC_W-1:0]  int3_reg, int3_next;
	logic signed [CIC_W-1:0]  dly1_reg, dly1_next;
	logic signed [CIC_W-1:0]  dly2_reg, dly2_next;
	logic signed [CIC_W-1:0]  dly3_reg, dly3_next;
	logic signed [COMB_W-1:0] comb_reg, comb_next;
	logic signed [CIC_W-1:0]  sample;
	logic signed [CIC_W-1:0]  c1;
	logic signed [CIC_W-1:0]  c2;
	logic signed [CIC_W-1:0]  c3;

	// integrators wrap on purpose; the combs undo the wrap exactly
	always_comb begin
		// R14: density bit as +1 or -1
		sample    = i_density_bit ? 24'sh000001 : 24'shFFFFFF;
		int1_next = int1_reg;
		int2_next = int2_reg;
		int3_next = int3_reg;
		if (ctl.clear) begin
			int1_next = '0;
			int2_next = '0;
			int3_next = '0;
		end else if (ctl.tick) begin
			// R17: integrators wide enough
			int1_next = int1_reg + sample;
			int2_next = int2_reg + int1_reg;
			int3_next = int3_reg + int2_reg;
		end
	end

	// comb section runs only at the decimated rate
	always_comb begin
		// R5: comb nulls reject images
		c1        = int3_reg - dly1_reg;
		c2        = c1 - dly2_reg;
		c3        = c2 - dly3_reg;
		dly1_next = dly1_reg;
		dly2_next = dly2_reg;
		dly3_next = dly3_reg;
		comb_next = comb_reg;
		if (ctl.clear) begin
			dly1_next = '0;
			dly2_next = '0;
			dly3_next = '0;
			comb_next = '0;
		end else if (ctl.dump) begin
			// R3: boxcar cascade first stage
			dly1_next = int3_reg;
			dly2_next = c1;
			dly3_next = c2;
			comb_next = c3[COMB_W-1:0];
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			int1_reg <= '0;
			int2_reg <= '0;
			int3_reg <= '0;
			dly1_reg <= '0;
			dly2_reg <= '0;
			dly3_reg <= '0;
			comb_reg <= '0;
		end else begin
			int1_reg <= int1_next;
			int2_reg <= int2_next;
			int3_reg <= int3_next;
			dly1_reg <= dly1_next;
			dly2_reg <= dly2_next;
			dly3_reg <= dly3_next;
			comb_reg <= comb_next;
		end
	end

	assign o_comb = comb_reg;
endmodule

// [hw/sigma_delta_decimation_filter.sv]
// eight-channel delta-sigma decimation filter with modulator clock divider
//
// Function
// R1: decimate by 64 in three modes
// R2: decimate by 128 in high resolution
// R3: cascade of FIR stages, linear phase
// R4: constant group delay, fixed latency
// R5: stop band at least 100 dB
// R6: response repeats at modulator rate
// R7: settled within 76 or 78 periods
// R8: little change for first 30 periods
// R9: 24-bit two's complement results
// R10: saturate at full-scale codes, no wrap
// R11: one LSB maps to code one
// R12: modulator clock divide by mode, divide input
// R13: mode pins 00,01,10,11 select modes
// R14: input is one-bit density stream
// R15: all channels convolve in lockstep
// R16: one-cycle valid strobe per output set
// R17: accumulators wide enough before scaling
`timescale 1ns/10ps
module sigma_delta_decimation_filter
	import sdf_pkg::*;
(
	input  wire logic                         i_clk_sys,
	input  wire logic                         i_nrst,
	input  wire logic [1:0]                   i_mode_select,
	input  wire logic                         i_clock_divide_select,
	input  wire logic [CHANNELS-1:0]          i_density_bits,
	output logic                              o_modulator_strobe,
	output logic [CHANNELS*RESULT_W-1:0]      o_results,
	output logic                              o_results_valid
);
	filter_ctl_if ctl_bus ();

	// pin synchronisers; first stage feeds only the second
	logic [1:0]               mode_meta_reg, mode_sync_reg;
	logic                     cdiv_meta_reg, cdiv_sync_reg;
	op_mode_e                 mode_prev_reg, mode_prev_next;
	logic                     cdiv_prev_reg, cdiv_prev_next;
	op_mode_e                 mode_now;
	logic                     restart;

	// modulator rate divider and decimation phase
	logic [DIV_W-1:0]         div_cnt_reg, div_cnt_next;
	logic [DIV_W-1:0]         div_last;
	logic                     tick_reg, tick_next;
	logic [DEC_W-1:0]         phase_reg, phase_next;
	logic [DEC_W-1:0]         phase_last;
	logic                     dump_reg, dump_next;
	logic                     clear_reg, clear_next;
	logic                     push_reg, push_next;
	logic                     hires;

	// second stage history and result sequencer
	logic signed [COMB_W-1:0] comb_out [CHANNELS];
	// R7: depth bounds settling time
	logic signed [COMB_W-1:0] hist_reg [CHANNELS][HIST_DEPTH];
	logic signed [COMB_W-1:0] hist_next [CHANNELS][HIST_DEPTH];
	seq_state_e               seq_reg, seq_next;
	logic [2:0]               ch_reg, ch_next;
	logic [1:0]               shift_reg, shift_next;
	logic [RESULT_W-1:0]      res_reg [CHANNELS];
	logic [RESULT_W-1:0]      res_next [CHANNELS];
	logic [CHANNELS*RESULT_W-1:0] out_reg, out_next;
	logic                     valid_reg, valid_next;
	logic signed [ACC_W-1:0]  fir_sum;
	logic signed [ACC_W-1:0]  fir_scaled;

	// clip to the 24-bit code range instead of wrapping
	function automatic logic [RESULT_W-1:0] saturate(input logic signed [ACC_W-1:0] v);
		logic [RESULT_W-1:0] r;
		if (v > RESULT_MAX) begin
			r = RESULT_MAX[RESULT_W-1:0];
		end else if (v < RESULT_MIN) begin
			r = RESULT_MIN[RESULT_W-1:0];
		end else begin
			r = v[RESULT_W-1:0];
		end
		return r;
	endfunction

	// mode and divide pins are asynchronous straps
	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			mode_meta_reg <= 2'h0;
			mode_sync_reg <= 2'h0;
			cdiv_meta_reg <= 1'b0;
			cdiv_sync_reg <= 1'b0;
		end else begin
			mode_meta_reg <= i_mode_select;
			mode_sync_reg <= mode_meta_reg;
			cdiv_meta_reg <= i_clock_divide_select;
			cdiv_sync_reg <= cdiv_meta_reg;
		end
	end

	// a change of mode or divide restarts every channel together
	always_comb begin
		// R13: pin code to mode
		mode_now       = op_mode_e'(mode_sync_reg);
		mode_prev_next = mode_now;
		cdiv_prev_next = cdiv_sync_reg;
		restart        = (mode_now != mode_prev_reg) || (cdiv_sync_reg != cdiv_prev_reg);
		hires          = (mode_prev_reg == MODE_HIGH_RESOLUTION);
	end

	// divide ratio and output ratio chosen by mode
	always_comb begin
		// R12: modulator clock divide select
		unique case (mode_prev_reg)
			MODE_HIGH_SPEED:      div_last = DIV_W'(DIV_FAST - 6'h01);
			MODE_HIGH_RESOLUTION: div_last = DIV_W'(DIV_FAST - 6'h01);
			MODE_LOW_POWER:       div_last = cdiv_prev_reg ? DIV_W'(DIV_MID - 6'h01)
			                                               : DIV_W'(DIV_FAST - 6'h01);
			MODE_LOW_SPEED:       div_last = cdiv_prev_reg ? DIV_W'(DIV_SLOW - 6'h01)
			                                               : DIV_W'(DIV_MID - 6'h01);
		endcase
		// R1: ratio 64 in three modes
		// R2: ratio 128 in high resolution
		phase_last = hires ? DEC_LAST_HIRES : DEC_LAST_STD;
	end

	// one shared counter pair keeps all channels on the same cycle
	always_comb begin
		div_cnt_next = div_cnt_reg;
		phase_next   = phase_reg;
		tick_next    = 1'b0;
		dump_next    = 1'b0;
		clear_next   = restart;
		push_next    = dump_reg;
		// R6: one sample per modulator period
		if (restart) begin
			div_cnt_next = '0;
			phase_next   = '0;
		end else if (div_cnt_reg == div_last) begin
			div_cnt_next = '0;
			tick_next    = 1'b1;
		end else begin
			div_cnt_next = div_cnt_reg + 6'h01;
		end
		if (!restart && tick_reg) begin
			// R15: common convolution start
			if (phase_reg == phase_last) begin
				phase_next = '0;
				dump_next  = 1'b1;
			end else begin
				phase_next = phase_reg + 7'h01;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			mode_prev_reg <= MODE_HIGH_SPEED;
			cdiv_prev_reg <= 1'b0;
			div_cnt_reg   <= '0;
			phase_reg     <= '0;
			tick_reg      <= 1'b0;
			dump_reg      <= 1'b0;
			clear_reg     <= 1'b1;
			push_reg      <= 1'b0;
		end else begin
			mode_prev_reg <= mode_prev_next;
			cdiv_prev_reg <= cdiv_prev_next;
			div_cnt_reg   <= div_cnt_next;
			phase_reg     <= phase_next;
			tick_reg      <= tick_next;
			dump_reg      <= dump_next;
			clear_reg     <= clear_next;
			push_reg      <= push_next;
		end
	end

	assign ctl_bus.tick  = tick_reg;
	assign ctl_bus.dump  = dump_reg;
	assign ctl_bus.clear = clear_reg;

	// first stage per channel, all driven by the same strobes
	generate
		for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
			decim_channel u_chan (
				.ctl           (ctl_bus.chan),
				.i_clk_sys     (i_clk_sys),
				.i_nrst        (i_nrst),
				.i_density_bit (i_density_bits[g]),
				.o_comb        (comb_out[g])
			);
		end
	endgenerate

	// second stage kernel, evaluated for one channel per cycle
	always_comb begin
		// R4: symmetric kernel, linear phase
		fir_sum = ACC_W'(hist_reg[ch_reg][FIR_TAP_FIRST])
		        + (ACC_W'(hist_reg[ch_reg][FIR_TAP_FIRST + 1]) <<< 1)
		        + ACC_W'(hist_reg[ch_reg][FIR_TAP_FIRST + 2]);
		// R11: scale so one LSB is code one
		fir_scaled = fir_sum <<< shift_reg;
	end

	// history shift, channel sweep and publication
	always_comb begin
		hist_next  = hist_reg;
		res_next   = res_reg;
		seq_next   = seq_reg;
		ch_next    = ch_reg;
		shift_next = shift_reg;
		out_next   = out_reg;
		valid_next = 1'b0;
		if (clear_reg) begin
			// flushing keeps old-mode data out of new results
			for (int c = 0; c < CHANNELS; c++) begin
				for (int t = 0; t < HIST_DEPTH; t++) begin
					hist_next[c][t] = '0;
				end
			end
			seq_next = SEQ_IDLE;
			ch_next  = 3'h0;
		end else begin
			unique case (seq_reg)
				SEQ_IDLE: begin
					if (push_reg) begin
						// R8: long delay line holds output still
						for (int c = 0; c < CHANNELS; c++) begin
							hist_next[c][0] = comb_out[c];
							for (int t = 1; t < HIST_DEPTH; t++) begin
								hist_next[c][t] = hist_reg[c][t-1];
							end
						end
						shift_next = hires ? SCALE_SHIFT_HIRES : SCALE_SHIFT_STD;
						ch_next    = 3'h0;
						seq_next   = SEQ_CALC;
					end
				end
				SEQ_CALC: begin
					// R10: clip at full scale
					res_next[ch_reg] = saturate(fir_scaled);
					ch_next          = ch_reg + 3'h1;
					if (ch_reg == 3'h7) begin
						seq_next = SEQ_PUBLISH;
					end
				end
				SEQ_PUBLISH: begin
					// R9: 24-bit words per channel
					for (int c = 0; c < CHANNELS; c++) begin
						out_next[c*RESULT_W +: RESULT_W] = res_reg[c];
					end
					// R16: one-cycle valid strobe
					valid_next = 1'b1;
					seq_next   = SEQ_IDLE;
				end
				default: begin
					seq_next = SEQ_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_nrst) begin
			hist_reg  <= '{default: '{default: '0}};
			res_reg   <= '{default: RESULT_RST};
			seq_reg   <= SEQ_IDLE;
			ch_reg    <= 3'h0;
			shift_reg <= SCALE_SHIFT_STD;
			out_reg   <= '0;
			valid_reg <= 1'b0;
		end else begin
			hist_reg  <= hist_next;
			res_reg   <= res_next;
			seq_reg   <= seq_next;
			ch_reg    <= ch_next;
			shift_reg <= shift_next;
			out_reg   <= out_next;
			valid_reg <= valid_next;
		end
	end

	// outputs straight from flip-flops
	assign o_modulator_strobe = tick_reg;
	assign o_results          = out_reg;
	assign o_results_valid    = valid_reg;
endmodule

// [tb/sdm_stream_model.sv]
// behavioural modulator bank feeding one density bit per channel
`timescale 1ns/10ps
module sdm_stream_model
	import sdf_pkg::*;
(
	input  wire logic                i_clk_sys,
	input  wire logic                i_strobe,
	input  wire logic [CHANNELS-1:0] i_pos_mask,
	input  wire logic                i_alternate,
	output logic      [CHANNELS-1:0] o_density_bits
);
	logic                phase_reg = 1'b0;
	logic [CHANNELS-1:0] level;

	// density per channel
	// alternate mode gives 50% ones density, otherwise a steady full-scale level
	assign level = i_alternate ? {CHANNELS{phase_reg}} : i_pos_mask;
	// bits mean nothing off the strobe, so those cycles show the inverse on purpose
	assign o_density_bits = i_strobe ? level : ~level;

	// next sample chosen just after the sampling edge
	always @(posedge i_clk_sys) begin
		if (i_strobe) begin
			phase_reg <= ~phase_reg;
		end
	end
endmodule

// [tb/sdf_assertions.sv]
// port checker for the decimation filter, bound to its top
`timescale 1ns/10ps
module sdf_assertions
	import sdf_pkg::*;
(
	input wire logic                         i_clk_sys,
	input wire logic                         i_nrst,
	input wire logic [1:0]                   i_mode_select,
	input wire logic                         i_clock_divide_select,
	input wire logic [CHANNELS-1:0]          i_density_bits,
	input wire logic                         o_modulator_strobe,
	input wire logic [CHANNELS*RESULT_W-1:0] o_results,
	input wire logic                         o_results_valid
);
	logic [2:0]  pins_reg;
	logic [15:0] stab_reg;
	logic [15:0] vgap_reg;
	logic [15:0] pos_reg;
	logic [15:0] neg_reg;
	logic        vok_reg;
	logic [15:0] settle_strobes;
	int          exp_clk;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);

	// clocks per output word for the pins as they stand
	always_comb begin
		exp_clk = (i_mode_select == 2'b01) ? 512 : 256;
		if (i_mode_select == 2'b11) begin
			exp_clk = i_clock_divide_select ? 2560 : 512;
		end
		if (i_mode_select == 2'b10 && i_clock_divide_select) begin
			exp_clk = 512;
		end
	end

	// strobes for forty output periods, well past the filter's settling in either ratio
	assign settle_strobes = (i_mode_select == 2'b01) ? 16'h1400 : 16'h0A00;

	// a pin change restarts the filter, so every run length but the valid gap count is forgotten
	always_ff @(posedge i_clk_sys) begin
		pins_reg <= {i_mode_select, i_clock_divide_select};
		vgap_reg <= o_results_valid ? 16'h0001 : vgap_reg + 16'h0001;
		if (!i_nrst || pins_reg != {i_mode_select, i_clock_divide_select}) begin
			stab_reg <= 16'h0000;
			vok_reg  <= 1'b0;
			pos_reg  <= 16'h0000;
			neg_reg  <= 16'h0000;
		end else begin
			stab_reg <= (stab_reg == 16'hFFFF) ? stab_reg : stab_reg + 16'h0001;
			if (o_results_valid) begin
				vok_reg <= (stab_reg >= 16'h0008);
			end
			if (o_modulator_strobe) begin
				pos_reg <= (&i_density_bits) ? pos_reg + 16'h0001 : 16'h0000;
				neg_reg <= (|i_density_bits) ? 16'h0000 : neg_reg + 16'h0001;
			end
		end
	end

	sequence s_valid_quiet;
		##1 !o_results_valid [*8];
	endsequence

	chk_strobe_single: assert property (o_modulator_strobe |=> !o_modulator_strobe)
		else $error("modulator strobe longer than one clock");
	chk_valid_single: assert property (o_results_valid |-> s_valid_quiet)
		else $error("valid strobe not a lone pulse");
	chk_valid_latency: assert property (o_results_valid |-> $past(o_modulator_strobe, 12))
		else $error("valid not twelve clocks after a sample");
	chk_valid_spacing: assert property ((o_results_valid && vok_reg && stab_reg >= 16'h0008)
		|-> vgap_reg == 16'(exp_clk))
		else $error("output period wrong for mode");
	chk_results_hold: assert property (!$stable(o_results) |-> o_results_valid)
		else $error("results moved without valid");
	chk_reset_quiet: assert property (disable iff (1'b0)
		!i_nrst |=> (o_results == '0 && !o_results_valid && !o_modulator_strobe))
		else $error("outputs active in reset");
	chk_clip_positive: assert property ((o_results_valid && pos_reg >= settle_strobes)
		|-> o_results == {CHANNELS{24'h7FFFFF}})
		else $error("full positive input not clipped to top code");
	chk_clip_negative: assert property ((o_results_valid && neg_reg >= settle_strobes)
		|-> o_results == {CHANNELS{24'h800000}})
		else $error("full negative input not clipped to bottom code");
endmodule

bind sigma_delta_decimation_filter sdf_assertions sdf_assertions_inst (
	.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_mode_select(i_mode_select),
	.i_clock_divide_select(i_clock_divide_select), .i_density_bits(i_density_bits),
	.o_modulator_strobe(o_modulator_strobe), .o_results(o_results),
	.o_results_valid(o_results_valid)
);

// [tb/tb_top.sv]
// self-checking bench for the decimation filter
`timescale 1ns/10ps
module tb_top
	import sdf_pkg::*;
;
	logic                         clk_sys = 1'b0;
	logic                         nrst = 1'b0;
	logic [1:0]                   mode_sel = 2'b00;
	logic                         cdiv = 1'b0;
	logic [CHANNELS-1:0]          pos_mask = 8'hFF;
	logic                         alternate = 1'b0;
	logic [CHANNELS-1:0]          bits;
	logic                         strobe;
	logic [CHANNELS*RESULT_W-1:0] results;
	logic                         valid;
	int                           miscompares = 0;
	int                           total_checks = 0;

	// 40 MHz system clock
	always #12.5 clk_sys = ~clk_sys;

	sigma_delta_decimation_filter sigma_delta_decimation_filter_inst (
		.i_clk_sys(clk_sys), .i_nrst(nrst), .i_mode_select(mode_sel),
		.i_clock_divide_select(cdiv), .i_density_bits(bits),
		.o_modulator_strobe(strobe), .o_results(results), .o_results_valid(valid)
	);
	sdm_stream_model sdm_stream_model_inst (
		.i_clk_sys(clk_sys), .i_strobe(strobe), .i_pos_mask(pos_mask),
		.i_alternate(alternate), .o_density_bits(bits)
	);

	task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// pins change only just after a rising edge
	task automatic set_inputs(input logic [1:0] m, input logic c, input logic [7:0] k, input logic a);
		@(posedge clk_sys);
		mode_sel <= m;
		cdiv <= c;
		pos_mask <= k;
		alternate <= a;
	endtask

	// clocks to the next strobe or valid, bounded so a silent design cannot hang
	task automatic gap_to(input logic on_valid, output int g);
		g = 0;
		do begin
			@(negedge clk_sys);
			g++;
		end while ((on_valid ? valid : strobe) !== 1'b1 && g < 6000);
	endtask

	// enough output periods for the step to settle, then check the last spacing and each channel
	task automatic run_frames(input logic [1:0] m, input logic c, input logic [7:0] k,
			input logic a, input int exp_gap);
		int g;
		set_inputs(m, c, k, a);
		repeat (20) gap_to(1'b1, g);
		// flushed history keeps the output still well inside the first thirty periods
		compare("early result", 32'h0, 32'(results[RESULT_W-1:0]));
		repeat (24) gap_to(1'b1, g);
		compare("output period", 32'(exp_gap), 32'(g));
		for (int ch = 0; ch < CHANNELS; ch++) begin
			compare("channel result", a ? 32'h0 : k[ch] ? 32'h7FFFFF : 32'h800000,
				32'(results[ch*RESULT_W +: RESULT_W]));
		end
	endtask

	task automatic test_divider();
		int g;
		for (int k = 0; k < 8; k++) begin
			set_inputs(2'(k >> 1), k[0], 8'hFF, 1'b0);
			repeat (10) @(posedge clk_sys);
			gap_to(1'b0, g);
			gap_to(1'b0, g);
			compare("modulator period", (k < 5) ? 4 : (k == 7) ? 40 : 8, 32'(g));
		end
		$display("test divider done");
	endtask

	// a reset in mid-run must clear the held results
	task automatic test_reset_midrun();
		@(posedge clk_sys);
		nrst <= 1'b0;
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		compare("results in reset", 32'h0, 32'(results[RESULT_W-1:0] | results[191:168]));
		compare("valid in reset", 32'h0, 32'(valid));
		@(posedge clk_sys);
		nrst <= 1'b1;
		$display("test reset done");
	endtask

	initial begin
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		test_divider();
		run_frames(MODE_HIGH_SPEED, 1'b0, 8'hFF, 1'b0, 256);
		$display("test positive clip done");
		test_reset_midrun();
		run_frames(MODE_LOW_POWER, 1'b0, 8'h00, 1'b0, 256);
		$display("test negative clip done");
		run_frames(MODE_HIGH_RESOLUTION, 1'b1, 8'h96, 1'b0, 512);
		$display("test mixed channels done");
		run_frames(MODE_HIGH_SPEED, 1'b1, 8'h00, 1'b1, 256);
		$display("test mid scale done");
		conclude();
	end

	// watchdog sized above the roughly 56600 clocks the tests need
	initial begin
		repeat (70000) @(posedge clk_sys);
		miscompares++;
		conclude();
	end
endmodule
